// ==== pkg/cgc_pkg.sv ====
// cgc_pkg: register indexes, field positions and reset values of the global
// configuration bank.
// assumes: 8-bit register index and 8-bit data on a plain strobe port.
package cgc_pkg;

	// register indexes, used directly as port addresses
	localparam logic [7:0] CGC_IDX_SOFT_RESET  = 8'h02;
	localparam logic [7:0] CGC_IDX_LDEV_SELECT = 8'h07;
	localparam logic [7:0] CGC_IDX_IDENTITY    = 8'h20;
	localparam logic [7:0] CGC_IDX_REVISION    = 8'h21;
	localparam logic [7:0] CGC_IDX_FUNC_POWER  = 8'h22;
	localparam logic [7:0] CGC_IDX_POWERDOWN   = 8'h23;
	localparam logic [7:0] CGC_IDX_ADDR_DECODE = 8'h24;

	// per-device window, routed to the selected logical device
	localparam logic [7:0] CGC_IDX_LDEV_FIRST  = 8'h30;
	localparam logic [7:0] CGC_IDX_LDEV_LAST   = 8'h6F;
	localparam int         CGC_LDEV_WORDS_W    = 6;

	// reset values
	localparam logic [7:0] CGC_RST_SOFT_RESET  = 8'h00;
	localparam logic [7:0] CGC_RST_LDEV_SELECT = 8'h00;
	localparam logic [7:0] CGC_RST_FUNC_POWER  = 8'hFF;
	localparam logic [7:0] CGC_RST_POWERDOWN   = 8'hFE;
	localparam logic [7:0] CGC_RST_ADDR_DECODE = 8'h80;

	// writable bits; the rest read back as their reset value
	localparam logic [7:0] CGC_MSK_SOFT_RESET  = 8'h01;
	localparam logic [7:0] CGC_MSK_FUNC_POWER  = 8'h3D;
	localparam logic [7:0] CGC_MSK_POWERDOWN   = 8'h01;
	localparam logic [7:0] CGC_MSK_ADDR_DECODE = 8'hFF;

	// strapped bits of the address decode register
	localparam logic [7:0] CGC_STRAP_MSK       = 8'h45;

	// field positions
	localparam int CGC_BIT_SOFT_RESET  = 0;
	localparam int CGC_BIT_SERIAL_B    = 5;
	localparam int CGC_BIT_SERIAL_A    = 4;
	localparam int CGC_BIT_PRINTER     = 3;
	localparam int CGC_BIT_INFRARED    = 2;
	localparam int CGC_BIT_FLOPPY      = 0;
	localparam int CGC_BIT_POWERDOWN   = 0;
	localparam int CGC_BIT_WIDE_ADDR   = 7;
	localparam int CGC_BIT_STRAP_HI    = 6;
	localparam int CGC_BIT_STRAP_MID   = 2;
	localparam int CGC_BIT_STRAP_LO    = 0;

	// host i/o address masks for 12 and 16 qualified bits
	localparam logic [15:0] CGC_ADDR_MASK_12 = 16'h0FFF;
	localparam logic [15:0] CGC_ADDR_MASK_16 = 16'hFFFF;

	localparam logic [7:0] CGC_UNMAPPED_DATA = 8'h00;

endpackage : cgc_pkg

// ==== rtl/cgc_ldev_ram.sv ====
// cgc_ldev_ram: small single-port store for the per-device registers.
// assumes: one clock, write and read never in the same cycle; read data registered.
`timescale 1ns/1ps
module cgc_ldev_ram #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 10
) (
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);

	// refuse shapes the store cannot hold; a wider address would make an unreasonable array
	if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad_shape
		$error("cgc_ldev_ram: DATA_W or ADDR_W out of range");
	end

	logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

	// no reset on the array: contents are undefined until software writes them
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_reg[addr] <= wdata;
		end
	end

	// read port registered so data stand in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rd_en) begin
			rdata <= mem_reg[addr];
		end
	end

endmodule : cgc_ldev_ram

// ==== rtl/cgc_global_regs.sv ====
// cgc_global_regs: global configuration register bank of the i/o controller.
// assumes: single clk, synchronous sys_rst held at least two cycles, plain
// strobe register port, strap pins asynchronous to clk.
`timescale 1ns/1ps
module cgc_global_regs
	import cgc_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID    = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_REV   = 8'h01, // arbitrary value
	parameter int         LDEV_COUNT   = 16
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [2:0]  strap_pins,
	output logic             soft_reset_request,
	output logic      [7:0]  logical_device_number,
	output logic             serial_b_power_on,
	output logic             serial_a_power_on,
	output logic             printer_port_power_on,
	output logic             infrared_power_on,
	output logic             floppy_ctrl_power_on,
	output logic             whole_chip_powerdown_now,
	output logic             wide_address_qualify,
	output logic      [15:0] io_addr_mask
);

	localparam int LDN_W = (LDEV_COUNT > 1) ? $clog2(LDEV_COUNT) : 1;
	localparam int RAM_W = LDN_W + CGC_LDEV_WORDS_W;

	// refuse sizes the logical device number cannot address
	if (LDEV_COUNT < 1 || LDEV_COUNT > 256) begin : g_bad_count
		$error("cgc_global_regs: LDEV_COUNT must be 1 to 256");
	end

	logic [7:0]  soft_reset_reg;
	logic [7:0]  ldev_select_reg;
	logic [7:0]  func_power_reg;
	logic [7:0]  powerdown_reg;
	logic [7:0]  addr_decode_reg;
	logic [7:0]  rdata_reg;
	logic        rd_ram_reg;
	logic        rd_any_reg;
	logic [2:0]  strap_meta_reg;
	logic [2:0]  strap_sync_reg;
	logic        strap_load_reg;
	logic [15:0] addr_mask_reg;
	logic [7:0]  ram_rdata;
	logic        ldev_hit;
	logic        ram_wr;
	logic        ram_rd;
	logic [RAM_W-1:0] ram_addr;

	// true when the index falls in the per-device window
	function automatic logic in_ldev_window(input logic [7:0] idx);
		in_ldev_window = (idx >= CGC_IDX_LDEV_FIRST) && (idx <= CGC_IDX_LDEV_LAST);
	endfunction : in_ldev_window

	// masked write: only writable bits change, reserved bits keep their value
	function automatic logic [7:0] merge_write(input logic [7:0] old_val,
		input logic [7:0] new_val, input logic [7:0] wmask);
		merge_write = (old_val & ~wmask) | (new_val & wmask);
	endfunction : merge_write

	// read decode of the global registers
	function automatic logic [7:0] global_read(input logic [7:0] idx,
		input logic [7:0] sr, input logic [7:0] ld, input logic [7:0] fp,
		input logic [7:0] pd, input logic [7:0] ad);
		case (idx)
			CGC_IDX_SOFT_RESET:  global_read = sr;
			CGC_IDX_LDEV_SELECT: global_read = ld;
			CGC_IDX_IDENTITY:    global_read = DEVICE_ID;
			CGC_IDX_REVISION:    global_read = DEVICE_REV;
			CGC_IDX_FUNC_POWER:  global_read = fp;
			CGC_IDX_POWERDOWN:   global_read = pd;
			CGC_IDX_ADDR_DECODE: global_read = ad;
			default:             global_read = CGC_UNMAPPED_DATA;
		endcase
	endfunction : global_read

	// soft reset request bit; reserved bits stay zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_reset_reg <= CGC_RST_SOFT_RESET;
		end else if (reg_wr && reg_addr == CGC_IDX_SOFT_RESET) begin
			soft_reset_reg <= merge_write(soft_reset_reg, reg_wdata, CGC_MSK_SOFT_RESET);
		end
	end

	// logical device number, full byte writable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ldev_select_reg <= CGC_RST_LDEV_SELECT;
		end else if (reg_wr && reg_addr == CGC_IDX_LDEV_SELECT) begin
			ldev_select_reg <= reg_wdata;
		end
	end

	// function power enables, 1 keeps the function running
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			func_power_reg <= CGC_RST_FUNC_POWER;
		end else if (reg_wr && reg_addr == CGC_IDX_FUNC_POWER) begin
			func_power_reg <= merge_write(func_power_reg, reg_wdata, CGC_MSK_FUNC_POWER);
		end
	end

	// immediate whole-chip power down
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			powerdown_reg <= CGC_RST_POWERDOWN;
		end else if (reg_wr && reg_addr == CGC_IDX_POWERDOWN) begin
			powerdown_reg <= merge_write(powerdown_reg, reg_wdata, CGC_MSK_POWERDOWN);
		end
	end

	// strap pins cross into clk through two flops; the first flop feeds only the second
	always_ff @(posedge clk) begin
		strap_meta_reg <= strap_pins;
		strap_sync_reg <= strap_meta_reg;
	end

	// strap capture happens once, on the first edge after reset release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strap_load_reg <= 1'b1;
		end else begin
			strap_load_reg <= 1'b0;
		end
	end

	// address decode control; a software write in the strap cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_decode_reg <= CGC_RST_ADDR_DECODE;
		end else if (reg_wr && reg_addr == CGC_IDX_ADDR_DECODE) begin
			addr_decode_reg <= merge_write(addr_decode_reg, reg_wdata, CGC_MSK_ADDR_DECODE);
		end else if (strap_load_reg) begin
			addr_decode_reg[CGC_BIT_STRAP_HI]  <= strap_sync_reg[2];
			addr_decode_reg[CGC_BIT_STRAP_MID] <= strap_sync_reg[1];
			addr_decode_reg[CGC_BIT_STRAP_LO]  <= strap_sync_reg[0];
		end
	end

	// qualifying mask for the host decoder, registered to keep it glitch free
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_mask_reg <= CGC_ADDR_MASK_16;
		end else if (addr_decode_reg[CGC_BIT_WIDE_ADDR]) begin
			addr_mask_reg <= CGC_ADDR_MASK_16;
		end else begin
			addr_mask_reg <= CGC_ADDR_MASK_12;
		end
	end

	// per-device window is live only when the selected device exists
	assign ldev_hit = in_ldev_window(reg_addr) && (ldev_select_reg < 9'(LDEV_COUNT));
	assign ram_wr   = reg_wr && ldev_hit;
	assign ram_rd   = reg_rd && ldev_hit;
	// ram address is device number over word offset, so devices never alias
	assign ram_addr = {ldev_select_reg[LDN_W-1:0],
		CGC_LDEV_WORDS_W'(reg_addr - CGC_IDX_LDEV_FIRST)};

	cgc_ldev_ram #(
		.DATA_W (8),
		.ADDR_W (RAM_W)
	) u_ldev_ram (
		.clk   (clk),
		.wr_en (ram_wr),
		.rd_en (ram_rd),
		.addr  (ram_addr),
		.wdata (reg_wdata),
		.rdata (ram_rdata)
	);

	// global read data; identity and revision are constants, so writes cannot alter them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg <= CGC_UNMAPPED_DATA;
		end else if (reg_rd) begin
			rdata_reg <= global_read(reg_addr, soft_reset_reg, ldev_select_reg,
				func_power_reg, powerdown_reg, addr_decode_reg);
		end
	end

	// remembers which source answers, so data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_ram_reg <= 1'b0;
			rd_any_reg <= 1'b0;
		end else begin
			rd_ram_reg <= ram_rd;
			rd_any_reg <= reg_rd;
		end
	end

	// read data are zero outside the answer cycle
	always_comb begin
		if (!rd_any_reg) begin
			reg_rdata = CGC_UNMAPPED_DATA;
		end else if (rd_ram_reg) begin
			reg_rdata = ram_rdata;
		end else begin
			reg_rdata = rdata_reg;
		end
	end

	// whole-chip power down overrides every function enable
	assign soft_reset_request       = soft_reset_reg[CGC_BIT_SOFT_RESET];
	assign logical_device_number    = ldev_select_reg;
	assign whole_chip_powerdown_now = powerdown_reg[CGC_BIT_POWERDOWN];
	assign serial_b_power_on        = func_power_reg[CGC_BIT_SERIAL_B] & ~whole_chip_powerdown_now;
	assign serial_a_power_on        = func_power_reg[CGC_BIT_SERIAL_A] & ~whole_chip_powerdown_now;
	assign printer_port_power_on    = func_power_reg[CGC_BIT_PRINTER] & ~whole_chip_powerdown_now;
	assign infrared_power_on        = func_power_reg[CGC_BIT_INFRARED] & ~whole_chip_powerdown_now;
	assign floppy_ctrl_power_on     = func_power_reg[CGC_BIT_FLOPPY] & ~whole_chip_powerdown_now;
	assign wide_address_qualify     = addr_decode_reg[CGC_BIT_WIDE_ADDR];
	assign io_addr_mask             = addr_mask_reg;

	// checks

	AST_SOFT_RESET_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_SOFT_RESET
		|=> soft_reset_request == $past(reg_wdata[0]))
		else $error("soft reset request did not follow write");

	AST_SOFT_RESET_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == CGC_IDX_SOFT_RESET
		|=> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == soft_reset_request)
		else $error("soft reset register read wrong");

	AST_LDN_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_LDEV_SELECT
		|=> logical_device_number == $past(reg_wdata))
		else $error("logical device number not stored");

	AST_IDENTITY_READ: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == CGC_IDX_IDENTITY |=> reg_rdata == DEVICE_ID)
		else $error("identity code read wrong");

	AST_REVISION_READ: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_REVISION ##1 reg_rd && reg_addr == CGC_IDX_REVISION
		|=> reg_rdata == DEVICE_REV)
		else $error("revision code changed by write");

	AST_POWER_RESET: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> func_power_reg == CGC_RST_FUNC_POWER
			&& serial_a_power_on && floppy_ctrl_power_on)
		else $error("function power not all on after reset");

	AST_POWER_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_FUNC_POWER && !whole_chip_powerdown_now
			&& !(reg_wr && reg_addr == CGC_IDX_POWERDOWN)
		|=> serial_b_power_on == $past(reg_wdata[5]) && printer_port_power_on ==
			$past(reg_wdata[3]) && infrared_power_on == $past(reg_wdata[2])
			&& func_power_reg[1] && func_power_reg[7:6] == 2'b11)
		else $error("function power bits wrong after write");

	AST_IMMEDIATE_POWERDOWN: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_POWERDOWN && reg_wdata[0]
		|=> whole_chip_powerdown_now && !serial_a_power_on && !serial_b_power_on
			&& !printer_port_power_on && !infrared_power_on && !floppy_ctrl_power_on)
		else $error("chip did not power down at once");

	AST_DECODE_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_ADDR_DECODE
		|=> ##1 io_addr_mask == ($past(reg_wdata[7], 2) ? CGC_ADDR_MASK_16 : CGC_ADDR_MASK_12))
		else $error("address decode width wrong");

	AST_LDEV_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && ldev_hit ##1 reg_rd && reg_addr == $past(reg_addr)
			&& $stable(ldev_select_reg)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("per-device data not routed to selected device");

	// reset-release checks carry no disable: they must see the first edge after release
	// the mask check leans on $past, so it is only meaningful once reset has let go
	AST_SOFT_RESET_CLEARED: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> !soft_reset_request
			&& soft_reset_reg == CGC_RST_SOFT_RESET)
		else $error("soft reset request not cleared by reset");

	AST_LDN_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
		!(reg_wr && reg_addr == CGC_IDX_LDEV_SELECT)
		|=> $stable(logical_device_number))
		else $error("logical device number changed without a write");

	AST_ANSWER_ONE_CYCLE: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == CGC_UNMAPPED_DATA)
		else $error("read data shown outside the answer cycle");

	AST_POWER_RESERVED_READ: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == CGC_IDX_FUNC_POWER
		|=> reg_rdata[7:6] == 2'b11 && reg_rdata[1])
		else $error("function power reserved bits read wrong");

	AST_POWER_WRITE_LOW: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_FUNC_POWER && !whole_chip_powerdown_now
		|=> serial_a_power_on == $past(reg_wdata[CGC_BIT_SERIAL_A])
			&& floppy_ctrl_power_on == $past(reg_wdata[CGC_BIT_FLOPPY]))
		else $error("serial a or floppy power wrong after write");

	AST_POWERDOWN_READ: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == CGC_IDX_POWERDOWN
		|=> reg_rdata[7:1] == 7'h7F && reg_rdata[0] == whole_chip_powerdown_now)
		else $error("power down register read wrong");

	AST_POWERDOWN_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_POWERDOWN && !reg_wdata[CGC_BIT_POWERDOWN]
		|=> !whole_chip_powerdown_now
			&& serial_b_power_on == func_power_reg[CGC_BIT_SERIAL_B])
		else $error("functions not restored after power down cleared");

	AST_WIDE_RESET: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> wide_address_qualify
			&& io_addr_mask == CGC_ADDR_MASK_16)
		else $error("decode width not 16 bits after reset");

	AST_WIDE_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == CGC_IDX_ADDR_DECODE
		|=> wide_address_qualify == $past(reg_wdata[CGC_BIT_WIDE_ADDR]))
		else $error("decode width bit not stored");

	AST_MASK_FOLLOWS_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
		io_addr_mask == ($past(wide_address_qualify) ? CGC_ADDR_MASK_16 : CGC_ADDR_MASK_12))
		else $error("address mask does not follow decode width");

	AST_LDEV_ABSENT: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && in_ldev_window(reg_addr) && (ldev_select_reg >= 9'(LDEV_COUNT))
		|=> reg_rdata == CGC_UNMAPPED_DATA)
		else $error("window of an absent device did not read empty");

endmodule : cgc_global_regs

// ==== verification/tb_cgc_global_regs.sv ====
// tb_cgc_global_regs: self-checking bench for the global configuration bank.
// assumes: cgc_pkg compiled first; bench drives the plain strobe port itself,
// read data captured one cycle after the read strobe.
`timescale 1ns/1ps
module tb_cgc_global_regs import cgc_pkg::*;;

	localparam logic [7:0] TB_ID  = 8'h3C; // arbitrary value
	localparam logic [7:0] TB_REV = 8'hC3; // arbitrary value

	logic        clk;
	logic        sys_rst;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [2:0]  strap_pins;
	logic        soft_reset_request;
	logic [7:0]  logical_device_number;
	logic        serial_b_power_on;
	logic        serial_a_power_on;
	logic        printer_port_power_on;
	logic        infrared_power_on;
	logic        floppy_ctrl_power_on;
	logic        whole_chip_powerdown_now;
	logic        wide_address_qualify;
	logic [15:0] io_addr_mask;
	int          n_mismatch;
	int          comparisons;
	int          cycles;

	// power outputs packed at their register bit positions for one compare
	wire logic [7:0] pwr_vec = {2'h0, serial_b_power_on, serial_a_power_on,
		printer_port_power_on, infrared_power_on, 1'b0, floppy_ctrl_power_on};
	wire logic [7:0] flags   = {5'h00, soft_reset_request, whole_chip_powerdown_now,
		wide_address_qualify};

	cgc_global_regs #(.DEVICE_ID(TB_ID), .DEVICE_REV(TB_REV), .LDEV_COUNT(16)) u_dut (
		.clk                      (clk),
		.sys_rst                  (sys_rst),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.strap_pins               (strap_pins),
		.soft_reset_request       (soft_reset_request),
		.logical_device_number    (logical_device_number),
		.serial_b_power_on        (serial_b_power_on),
		.serial_a_power_on        (serial_a_power_on),
		.printer_port_power_on    (printer_port_power_on),
		.infrared_power_on        (infrared_power_on),
		.floppy_ctrl_power_on     (floppy_ctrl_power_on),
		.whole_chip_powerdown_now (whole_chip_powerdown_now),
		.wide_address_qualify     (wide_address_qualify),
		.io_addr_mask             (io_addr_mask)
	);

	// 250 MHz
	always #2 clk = ~clk;

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch = n_mismatch + 1;
			test_done();
		end
	end

	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write strobe; outputs are looked at on the following falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(negedge clk);
	endtask : wr

	// read data stand only in the cycle after the strobe, so capture there
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : rd_chk

	// write then read with no gap between the strobes, as the port allows
	task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : wr_rd_chk

	task automatic t_reset(input logic [7:0] e24);
		rd_chk(8'h02, 8'h00);
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h22, 8'hFF);
		rd_chk(8'h23, 8'hFE);
		rd_chk(8'h24, e24);
		chk(pwr_vec, 8'h3D);
		chk(flags, 8'h01);
		chk(io_addr_mask[15:8], 8'hFF);
	endtask : t_reset

	task automatic t_soft();
		wr(8'h02, 8'hFF);
		rd_chk(8'h02, 8'h01);
		chk(flags, 8'h05);
		wr(8'h02, 8'h00);
		chk(flags, 8'h01);
	endtask : t_soft

	task automatic t_ident();
		wr(8'h20, 8'hFF);
		wr_rd_chk(8'h21, ~TB_REV, TB_REV);
		rd_chk(8'h20, TB_ID);
		@(negedge clk);
		chk(reg_rdata, 8'h00);
		rd_chk(8'h21, TB_REV);
		wr(8'h10, 8'h5A);
		rd_chk(8'h10, 8'h00);
	endtask : t_ident

	task automatic t_ldev();
		wr(8'h07, 8'hA5);
		rd_chk(8'h07, 8'hA5);
		chk(logical_device_number, 8'hA5);
		wr(8'h07, 8'h03);
		wr(8'h35, 8'hAB);
		wr(8'h6F, 8'h5E);
		wr(8'h07, 8'h04);
		wr(8'h35, 8'hCD);
		rd_chk(8'h35, 8'hCD);
		wr(8'h07, 8'h03);
		rd_chk(8'h35, 8'hAB);
		rd_chk(8'h6F, 8'h5E);
		wr_rd_chk(8'h36, 8'h77, 8'h77);
		// first number past the implemented devices: window reads empty
		wr(8'h07, 8'h10);
		rd_chk(8'h35, 8'h00);
	endtask : t_ldev

	task automatic t_power();
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			if (i != 1) begin
				v = ~(8'h01 << i);
				wr(8'h22, v);
				rd_chk(8'h22, v);
				chk(pwr_vec, v & 8'h3D);
			end
		end
		wr(8'h22, 8'h00);
		rd_chk(8'h22, 8'hC2);
		chk(pwr_vec, 8'h00);
		wr(8'h22, 8'hFF);
	endtask : t_power

	task automatic t_pd();
		wr(8'h23, 8'hFF);
		rd_chk(8'h23, 8'hFF);
		chk(flags, 8'h03);
		chk(pwr_vec, 8'h00);
		wr(8'h23, 8'h00);
		rd_chk(8'h23, 8'hFE);
		chk(pwr_vec, 8'h3D);
	endtask : t_pd

	// the mask lags the decode bit by one cycle, hence the extra falling edge
	task automatic t_addr();
		wr(8'h24, 8'h00);
		@(negedge clk);
		chk(flags, 8'h00);
		chk(io_addr_mask[15:8], 8'h0F);
		chk(io_addr_mask[7:0], 8'hFF);
		rd_chk(8'h24, 8'h00);
		wr(8'h24, 8'h80);
		@(negedge clk);
		chk(io_addr_mask[15:8], 8'hFF);
		chk(flags, 8'h01);
	endtask : t_addr

	// main sequence, with a second reset in mid-run to prove reset values return
	initial begin
		clk         = 1'b0;
		sys_rst     = 1'b1;
		reg_addr    = 8'h00;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		strap_pins  = 3'b101;
		n_mismatch  = 0;
		comparisons = 0;
		cycles      = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset(8'hC1);
		t_soft();
		t_ident();
		t_ldev();
		t_power();
		t_pd();
		t_addr();
		@(posedge clk);
		strap_pins <= 3'b010;
		sys_rst    <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset(8'h84);
		test_done();
	end

endmodule : tb_cgc_global_regs
